// ---- hdl/hcs_sequencer.sv ----
/*
  mode sequencer for an energy-harvesting boost charger: cold start,
  main charging, thermal shutdown, start-up timing and rail-to-battery switch.
  assumes asynchronous analog comparator levels on input and analog
  stages that obey the enables on output; 40 MHz time base.
*/
`timescale 1ns/1ps
`default_nettype none
`include "hcs_defs.svh"

// Behaviour
// - cold start when rail low, input adequate
// - clamp input to cold-start voltage then
// - all other functions idle in cold start except thermal shutdown
// - initialization pulse on divider bias first
// - charger off 32 ms after pulse
// - first feedback sample 64 ms after pulse
// - charger on at enable; switch at undervoltage
// - charged hot-plug, rail high: switch open
// - empty hot-plug: switch closed 45 ms
// - rail above undervoltage at 64 ms: close
// - otherwise switch waits for undervoltage plus hysteresis
// - pulse-frequency transfer only above reference
// - peak current from three levels
// - charger off at overvoltage threshold
// - pull input down when over overvoltage
// - select pin picks 65 or 120 C
// - overtemp disables charger, 5 C hysteresis
// - undervoltage opens switch even in shutdown
// - switch hysteresis between uv and uv+hyst
// - reference refresh 16 s, charger off 256 ms
// - divider bias cycle repeats every 64 ms
module hcs_sequencer
  import hcs_pkg::*;
#(
  parameter longint CLK_HZ = `HCS_CLK_HZ,
  parameter longint INIT_PULSE_CYC = (CLK_HZ * `HCS_INIT_PULSE_US) / 1000000,
  parameter longint CHG_OFF_CYC = (CLK_HZ * `HCS_CHG_OFF_MS) / 1000,
  parameter longint FIRST_SAMPLE_CYC = (CLK_HZ * `HCS_FIRST_SAMPLE_MS) / 1000,
  parameter longint HOT_PLUG_CYC = (CLK_HZ * `HCS_HOT_PLUG_MS) / 1000,
  parameter longint REFRESH_CYC = CLK_HZ * `HCS_REFRESH_S,
  parameter longint REFRESH_OFF_CYC = (CLK_HZ * `HCS_REFRESH_OFF_MS) / 1000,
  parameter longint BIAS_PERIOD_CYC = (CLK_HZ * `HCS_BIAS_PERIOD_MS) / 1000,
  parameter int PEAK_DWELL_CYC = 256
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_B,
  // comparator levels
  input wire hcs_pkg::hcs_cmp_t CMP,
  // enables to the analog stage
  output hcs_pkg::hcs_ctl_t CTL,
  output logic [3:0] MODE
);
  import hcs_pkg::*;

  localparam int TW = 34;

  // ----------------------------------------------------------------
  // comparator synchronisation
  // ----------------------------------------------------------------
  hcs_cmp_t cmp;
  hcs_sync #(.W($bits(hcs_cmp_t))) u_sync (
    .CLK(CLK),
    .RST_B(RST_B),
    .D(CMP),
    .Q(cmp)
  );

  // hold decisions until the synchroniser has filled; its zeros look like an empty rail
  logic [2:0] settle;
  logic settled;
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      settle <= 3'h0;
    end else if (!settled) begin
      settle <= settle + 3'h1;
    end
  end
  assign settled = (settle == 3'h7);

  // ----------------------------------------------------------------
  // sequence timer
  // ----------------------------------------------------------------
  hcs_state_t state;
  hcs_state_t next_state;
  logic t_start;
  logic [TW-1:0] t_load;
  logic t_done;
  logic [TW-1:0] since_pulse;

  hcs_timer #(.W(TW)) u_seq_timer (
    .CLK(CLK),
    .RST_B(RST_B),
    .START(t_start),
    .LOAD(t_load),
    .DONE(t_done),
    .BUSY()
  );

  // ----------------------------------------------------------------
  // thermal shutdown with hysteresis
  // ----------------------------------------------------------------
  logic hot;
  logic over;
  logic below_hyst;
  always_comb begin
    // select pin level chooses the trip point
    over = cmp.overtemp_select_pin ? cmp.temp_above_high : cmp.temp_above_low;
    below_hyst = cmp.overtemp_select_pin ? !cmp.temp_above_high_hyst
                                         : !cmp.temp_above_low_hyst;
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      hot <= 1'b0;
    end else if (over) begin
      hot <= 1'b1;
    end else if (below_hyst) begin
      hot <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // mode sequencing
  // ----------------------------------------------------------------
  logic cold_cond;
  assign cold_cond = !cmp.rail_above_chgen && cmp.input_above_cs && cmp.input_power_ok;

  always_comb begin
    next_state = state;
    t_start = 1'b0;
    t_load = '0;
    case (state)
      HCS_IDLE: begin
        if (!settled) begin
          next_state = HCS_IDLE;
        end else if (cold_cond) begin
          next_state = HCS_COLD;
        end else if (!cmp.rail_above_100mv && cmp.bat_above_100mv) begin
          // charged element plugged onto an empty rail
          next_state = HCS_HOT_PLUG;
          t_start = 1'b1;
          t_load = TW'(HOT_PLUG_CYC - 1);
        end else if (cmp.rail_above_chgen) begin
          next_state = HCS_INIT;
          t_start = 1'b1;
          t_load = TW'(INIT_PULSE_CYC - 1);
        end
      end
      HCS_COLD: begin
        if (cmp.rail_above_chgen) begin
          next_state = HCS_INIT;
          t_start = 1'b1;
          t_load = TW'(INIT_PULSE_CYC - 1);
        end else if (!cold_cond) begin
          next_state = HCS_IDLE;
        end
      end
      HCS_HOT_PLUG: begin
        if (t_done) begin
          next_state = HCS_INIT;
          t_start = 1'b1;
          t_load = TW'(INIT_PULSE_CYC - 1);
        end
      end
      HCS_INIT: begin
        if (t_done) begin
          next_state = HCS_CHG_OFF;
          t_start = 1'b1;
          t_load = TW'(CHG_OFF_CYC - 1);
        end
      end
      HCS_CHG_OFF: begin
        if (t_done) begin
          next_state = HCS_WAIT_SAMPLE;
        end
      end
      HCS_WAIT_SAMPLE: begin
        // first sample lands 64 ms after the pulse started
        if (since_pulse >= TW'(FIRST_SAMPLE_CYC)) begin
          next_state = cmp.rail_above_uv ? HCS_RUN : HCS_HOLD_OPEN;
        end
      end
      HCS_HOLD_OPEN: begin
        if (cold_cond) begin
          next_state = HCS_COLD;
        end else if (cmp.rail_above_uv) begin
          next_state = HCS_RUN;
        end
      end
      HCS_RUN: begin
        if (cold_cond) begin
          next_state = HCS_COLD;
        end
      end
      default: begin
        next_state = HCS_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      state <= HCS_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // time since the initialization pulse began
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      since_pulse <= '0;
    end else if (next_state == HCS_INIT && state != HCS_INIT) begin
      since_pulse <= '0;
    end else if (state == HCS_IDLE || state == HCS_COLD) begin
      since_pulse <= '0;
    end else if (since_pulse != {TW{1'b1}}) begin
      since_pulse <= since_pulse + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // hot-plug latch: charged element on a non-empty rail
  // ----------------------------------------------------------------
  logic hp_block;
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      hp_block <= 1'b0;
    end else if (cmp.input_source_present) begin
      hp_block <= 1'b0;
    end else if (state == HCS_IDLE && cmp.rail_above_100mv && cmp.bat_above_100mv) begin
      hp_block <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // switch with undervoltage hysteresis
  // ----------------------------------------------------------------
  logic sw;
  logic running;
  assign running = (state == HCS_RUN);
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      sw <= 1'b0;
    end else if (next_state == HCS_HOT_PLUG) begin
      sw <= 1'b1;
    end else if (state == HCS_WAIT_SAMPLE && next_state == HCS_RUN && !hp_block) begin
      // rail above undervoltage at the first sample
      sw <= 1'b1;
    end else if (!cmp.rail_above_uv || hp_block || !running) begin
      // opens even in thermal shutdown
      sw <= 1'b0;
    end else if (cmp.rail_above_uv_hyst) begin
      // rising threshold is undervoltage plus hysteresis
      sw <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // reference refresh and bias cycle
  // ----------------------------------------------------------------
  logic [TW-1:0] ref_cnt;
  logic ref_off;
  logic [TW-1:0] bias_cnt;
  logic bias_pulse;
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      ref_cnt <= '0;
      ref_off <= 1'b0;
    end else if (!running) begin
      ref_cnt <= '0;
      ref_off <= 1'b0;
    end else if (ref_cnt == TW'(REFRESH_CYC - 1)) begin
      ref_cnt <= '0;
      ref_off <= 1'b1;
    end else begin
      ref_cnt <= ref_cnt + 1'b1;
      if (ref_cnt == TW'(REFRESH_OFF_CYC - 1)) begin
        ref_off <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      bias_cnt <= '0;
      bias_pulse <= 1'b0;
    end else if (!running) begin
      bias_cnt <= '0;
      bias_pulse <= 1'b0;
    end else begin
      bias_cnt <= (bias_cnt == TW'(BIAS_PERIOD_CYC - 1)) ? '0 : bias_cnt + 1'b1;
      bias_pulse <= (bias_cnt < TW'(INIT_PULSE_CYC));
    end
  end

  // ----------------------------------------------------------------
  // peak current level dither
  // ----------------------------------------------------------------
  logic [`HCS_PEAK_LVL_W-1:0] lvl;
  logic [15:0] dwell;
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      lvl <= '0;
      dwell <= '0;
    end else if (dwell == 16'(PEAK_DWELL_CYC - 1)) begin
      dwell <= '0;
      // step up under strong input, back down otherwise
      if (cmp.input_above_ref && lvl != `HCS_PEAK_LVL_W'(`HCS_PEAK_LEVELS - 1)) begin
        lvl <= lvl + 1'b1;
      end else if (!cmp.input_above_ref && lvl != '0) begin
        lvl <= lvl - 1'b1;
      end
    end else begin
      dwell <= dwell + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  logic chg_allow;
  assign chg_allow = running || state == HCS_HOLD_OPEN || state == HCS_WAIT_SAMPLE;

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      CTL <= '0;
      MODE <= 4'h0;
    end else begin
      CTL.cold_start_en <= (state == HCS_COLD);
      CTL.input_clamp_en <= (state == HCS_COLD);
      // pfm transfer only above the held reference; off during ov, heat, refresh
      CTL.charger_en <= chg_allow && !cmp.rail_above_ov && !hot && !ref_off
                        && cmp.input_above_ref;
      CTL.switch_close <= sw;
      CTL.divider_bias_node <= (state == HCS_INIT) || bias_pulse;
      CTL.feedback_sample <= (state == HCS_WAIT_SAMPLE && next_state != state);
      CTL.reference_sample <= (state == HCS_CHG_OFF && t_done) || (running && ref_off);
      CTL.input_pulldown <= (state != HCS_COLD) && cmp.input_above_rail
                            && cmp.rail_above_ov;
      CTL.peak_level <= (state == HCS_COLD) ? '0 : lvl;
      CTL.thermal_shutdown <= hot;
      MODE <= state;
    end
  end
endmodule
`default_nettype wire

// ---- hdl/hcs_defs.svh ----
/*
  timing counts and field constants for the harvester charger mode sequencer.
  assumes a 40 MHz system clock; included by bare name.
*/
`ifndef HCS_DEFS_SVH
`define HCS_DEFS_SVH

// ----------------------------------------------------------------
// clock and intervals
// ----------------------------------------------------------------
`define HCS_CLK_HZ 40000000
`define HCS_INIT_PULSE_US 100
`define HCS_CHG_OFF_MS 32
`define HCS_FIRST_SAMPLE_MS 64
`define HCS_HOT_PLUG_MS 45
`define HCS_REFRESH_S 16
`define HCS_REFRESH_OFF_MS 256
`define HCS_BIAS_PERIOD_MS 64
`define HCS_OT_HYST_C 5
`define HCS_OT_LOW_C 65
`define HCS_OT_HIGH_C 120

// ----------------------------------------------------------------
// peak current levels
// ----------------------------------------------------------------
`define HCS_PEAK_LEVELS 3
`define HCS_AVG_LIMIT_MA 100
`define HCS_PEAK_NOM_MA 230
`define HCS_PEAK_LVL_W 2

`endif

// ---- hdl/hcs_pkg.sv ----
/*
  types shared by the sequencer and its helpers.
  assumes hcs_defs.svh for numbers.
*/
package hcs_pkg;

  typedef enum logic [3:0] {
    HCS_IDLE = 4'h0,
    HCS_COLD = 4'h1,
    HCS_HOT_PLUG = 4'h2,
    HCS_INIT = 4'h3,
    HCS_CHG_OFF = 4'h4,
    HCS_WAIT_SAMPLE = 4'h5,
    HCS_RUN = 4'h6,
    HCS_HOLD_OPEN = 4'h7
  } hcs_state_t;

  typedef struct packed {
    logic rail_above_chgen;
    logic rail_above_uv;
    logic rail_above_uv_hyst;
    logic rail_above_ov;
    logic rail_above_100mv;
    logic bat_above_100mv;
    logic input_above_cs;
    logic input_power_ok;
    logic input_above_ref;
    logic input_above_rail;
    logic temp_above_low;
    logic temp_above_high;
    logic temp_above_low_hyst;
    logic temp_above_high_hyst;
    logic overtemp_select_pin;
    logic input_source_present;
  } hcs_cmp_t;

  typedef struct packed {
    logic cold_start_en;
    logic input_clamp_en;
    logic charger_en;
    logic switch_close;
    logic divider_bias_node;
    logic feedback_sample;
    logic reference_sample;
    logic input_pulldown;
    logic [1:0] peak_level;
    logic thermal_shutdown;
  } hcs_ctl_t;

endpackage

// ---- hdl/hcs_sync.sv ----
/*
  three-flop synchroniser with agreement filter for comparator inputs.
  assumes asynchronous comparator levels; one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module hcs_sync #(
  parameter int W = 16
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_B,
  // levels
  input wire logic [W-1:0] D,
  output logic [W-1:0] Q
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  // s1 only feeds s2; a change counts once s2 and s3 agree
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      Q <= '0;
    end else begin
      s1 <= D;
      s2 <= s1;
      s3 <= s2;
      Q <= (s2 & s3) | (Q & (s2 | s3));
    end
  end
endmodule
`default_nettype wire

// ---- hdl/hcs_timer.sv ----
/*
  loadable down counter used for the hot-plug, init pulse and charger-off intervals.
  assumes one clock; start reloads, done pulses at zero.
*/
`timescale 1ns/1ps
`default_nettype none
module hcs_timer #(
  parameter int W = 34
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_B,
  // control
  input wire logic START,
  input wire logic [W-1:0] LOAD,
  output logic DONE,
  output logic BUSY
);
  logic [W-1:0] count;

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      count <= '0;
      DONE <= 1'b0;
    end else if (START) begin
      count <= LOAD;
      DONE <= 1'b0;
    end else begin
      DONE <= (count == {{(W-1){1'b0}}, 1'b1});
      if (count != '0) begin
        count <= count - 1'b1;
      end
    end
  end

  assign BUSY = (count != '0);
endmodule
`default_nettype wire

// ---- bench/hcs_far_model.sv ----
/*
  comparator bank facing the sequencer, levels in mV and degrees C.
  assumes the bench sets the analog levels; ideal comparators.
*/
`timescale 1ns/1ps
`default_nettype none
module hcs_far_model
  import hcs_pkg::*;
#(
  parameter int CHGEN = 1800,
  parameter int UV = 2200,
  parameter int UVH = 2300,
  parameter int OV = 3150,
  parameter int VCS = 330,
  parameter int REF = 300,
  parameter int TLO = 65,
  parameter int THI = 120,
  parameter int HYS = 5
) (
  // levels
  input wire logic [15:0] RAIL, // load kept off the rail by an outside isolator
  input wire logic [15:0] BAT,
  input wire logic [15:0] VIN,
  input wire logic [15:0] TEMP,
  input wire logic SEL,
  // comparators
  output var hcs_pkg::hcs_cmp_t CMP
);
  // ------------------------------------------------
  // comparators, no offset or delay
  // ------------------------------------------------
  always_comb begin
    CMP.rail_above_chgen = RAIL >= CHGEN;
    CMP.rail_above_uv = RAIL >= UV;
    CMP.rail_above_uv_hyst = RAIL >= UVH;
    CMP.rail_above_ov = RAIL >= OV;
    CMP.rail_above_100mv = RAIL > 100;
    CMP.bat_above_100mv = BAT > 100;
    CMP.input_above_cs = VIN >= VCS;
    // power follows voltage: no weak-source case
    CMP.input_power_ok = VIN >= VCS;
    CMP.input_above_ref = VIN > REF;
    CMP.input_above_rail = VIN > RAIL;
    CMP.temp_above_low = TEMP > TLO;
    CMP.temp_above_high = TEMP > THI;
    CMP.temp_above_low_hyst = TEMP > TLO - HYS;
    CMP.temp_above_high_hyst = TEMP > THI - HYS;
    CMP.overtemp_select_pin = SEL;
    CMP.input_source_present = VIN != 16'h0;
  end
endmodule
`default_nettype wire

// ---- bench/hcs_seq_properties.sv ----
/*
  concurrent checks on the sequencer ports.
  assumes comparator levels settle within the 8-cycle windows.
*/
`timescale 1ns/1ps
`default_nettype none
module hcs_seq_properties
  import hcs_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic RST_B,
  // ports watched
  input wire hcs_pkg::hcs_cmp_t CMP,
  input wire hcs_pkg::hcs_ctl_t CTL,
  input wire logic [3:0] MODE
);
  // ------------------------------------------------
  // properties
  // ------------------------------------------------
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_B);
  AST_COLD_ON: assert property (MODE == HCS_COLD |-> CTL.cold_start_en
    && CTL.input_clamp_en)
    else $error("cold mode without converter or clamp");
  AST_COLD_QUIET: assert property (MODE == HCS_COLD |-> !(CTL.charger_en
    || CTL.switch_close || CTL.divider_bias_node || CTL.feedback_sample))
    else $error("activity during cold start");
  AST_INIT_PULSE: assert property (MODE == HCS_INIT |-> CTL.divider_bias_node)
    else $error("init without bias pulse");
  AST_CHG_OFF: assert property (MODE == HCS_CHG_OFF |-> !CTL.charger_en)
    else $error("charger on in settle window");
  AST_OV_STOP: assert property (CMP.rail_above_ov [*8] |-> !CTL.charger_en)
    else $error("charger on above overvoltage");
  AST_PULLDOWN: assert property ((CMP.input_above_rail && CMP.rail_above_ov
    && MODE != HCS_COLD) [*8] |-> CTL.input_pulldown)
    else $error("input not pulled down");
  AST_HOT_LOW: assert property ((!CMP.overtemp_select_pin
    && CMP.temp_above_low) [*8] |-> CTL.thermal_shutdown && !CTL.charger_en)
    else $error("no shutdown at low threshold");
  AST_HOT_HIGH: assert property ((CMP.overtemp_select_pin
    && CMP.temp_above_high) [*8] |-> CTL.thermal_shutdown && !CTL.charger_en)
    else $error("no shutdown at high threshold");
  AST_UV_OPEN: assert property ((!CMP.rail_above_uv
    && MODE != HCS_HOT_PLUG) [*8] |-> !CTL.switch_close)
    else $error("switch closed below undervoltage");
  AST_SW_WHERE: assert property (CTL.switch_close |-> MODE == HCS_RUN
    || MODE == HCS_HOT_PLUG)
    else $error("switch closed in wrong mode");
  AST_PFM: assert property (!CMP.input_above_ref [*8] |-> !CTL.charger_en)
    else $error("transfer below reference");
  AST_PEAK: assert property (CTL.peak_level <= 2'h2)
    else $error("peak level out of range");
  COV_RUN: cover property (MODE == HCS_RUN && CTL.switch_close);
  COV_HOT: cover property (MODE == HCS_HOT_PLUG);
  COV_TSD: cover property (CTL.thermal_shutdown);
  COV_PD: cover property (CTL.input_pulldown);
endmodule
bind hcs_sequencer hcs_seq_properties u_prop (.CLK(CLK), .RST_B(RST_B), .CMP(CMP),
  .CTL(CTL), .MODE(MODE));
`default_nettype wire

// ---- bench/tb_top.sv ----
/*
  self-checking bench for the mode sequencer.
  assumes the far-side model and the bound checker; short counts.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import hcs_pkg::*;
  localparam int OFF_C = 32;
  localparam int FS_C = 64;
  localparam int HP_C = 45;
  localparam int RF_C = 6000;
  localparam int RFO_C = 256;
  localparam int BP_C = 64;
  logic CLK = 1'b0;
  logic RST_B = 1'b0;
  logic [15:0] rail = 16'h0;
  logic [15:0] bat = 16'h0;
  logic [15:0] vin = 16'h0;
  logic [15:0] temp = 16'h19;
  logic sel = 1'b0;
  hcs_cmp_t cmp;
  hcs_ctl_t ctl;
  logic [3:0] mode;
  int n_fail = 0;
  int check_count = 0;
  always #12.5 CLK = ~CLK;
  hcs_far_model far (.RAIL(rail), .BAT(bat), .VIN(vin), .TEMP(temp), .SEL(sel), .CMP(cmp));
  hcs_sequencer #(.INIT_PULSE_CYC(4), .CHG_OFF_CYC(OFF_C), .FIRST_SAMPLE_CYC(FS_C),
    .HOT_PLUG_CYC(HP_C), .REFRESH_CYC(RF_C), .REFRESH_OFF_CYC(RFO_C),
    .BIAS_PERIOD_CYC(BP_C), .PEAK_DWELL_CYC(8)) dut (.CLK(CLK), .RST_B(RST_B),
    .CMP(cmp), .CTL(ctl), .MODE(mode));
  // ------------------------------------------------
  // helpers
  // ------------------------------------------------
  task automatic chk_val(string nm, logic [3:0] e, logic [3:0] g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("FAIL %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic chk_near(string nm, int e, int g);
    check_count++;
    if (g < e - 3 || g > e + 3) begin
      n_fail++;
      $display("FAIL %s exp %0d got %0d", nm, e, g);
    end
  endtask
  task automatic close_out();
    $display("checks %0d fails %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // sample 1 ns after the edge, once its updates have landed
  task automatic tick();
    @(posedge CLK);
    #1;
  endtask
  task automatic cyc(int n);
    repeat (n) tick();
  endtask
  task automatic lvl(int r, int b, int v);
    @(posedge CLK);
    rail <= 16'(r);
    bat <= 16'(b);
    vin <= 16'(v);
  endtask
  task automatic heat(logic s, int t);
    @(posedge CLK);
    sel <= s;
    temp <= 16'(t);
  endtask
  task automatic rst(int r, int b, int v);
    lvl(r, b, v);
    RST_B <= 1'b0;
    repeat (20) @(posedge CLK);
    RST_B <= 1'b1;
    cyc(2);
  endtask
  task automatic wait_mode(logic [3:0] m);
    int i;
    i = 0;
    while (mode !== m && i < 400) begin
      tick();
      i++;
    end
    chk_val("mode", m, mode);
  endtask
  task automatic go_run();
    rst(500, 500, 400);
    wait_mode(HCS_COLD);
    lvl(2400, 500, 400);
    wait_mode(HCS_RUN);
    cyc(12);
  endtask
  task automatic bias_gap(output int n);
    n = 0;
    while (ctl.divider_bias_node === 1'b1 && n < 500) begin
      tick();
      n++;
    end
    while (ctl.divider_bias_node !== 1'b1 && n < 500) begin
      tick();
      n++;
    end
  endtask
  // ------------------------------------------------
  // scenarios
  // ------------------------------------------------
  task automatic t_cold();
    int k;
    int c;
    int s;
    rst(500, 500, 400);
    wait_mode(HCS_COLD);
    chk_val("clamp", 4'h1, ctl.input_clamp_en);
    chk_val("chg", 4'h0, ctl.charger_en);
    cyc(20);
    chk_val("cs", 4'h1, ctl.cold_start_en);
    chk_val("peak", 4'h0, ctl.peak_level);
    lvl(1900, 500, 400);
    wait_mode(HCS_INIT);
    chk_val("bias", 4'h1, ctl.divider_bias_node);
    c = 0;
    s = 0;
    for (k = 1; k < 200 && s == 0; k++) begin
      tick();
      if (mode === HCS_CHG_OFF) c++;
      if (ctl.feedback_sample === 1'b1) s = k;
    end
    chk_near("off", OFF_C, c);
    chk_near("sample", FS_C, s);
    wait_mode(HCS_HOLD_OPEN);
    lvl(2250, 500, 400);
    cyc(12);
    chk_val("sw", 4'h0, ctl.switch_close);
    lvl(2400, 500, 400);
    cyc(12);
    chk_val("sw", 4'h1, ctl.switch_close);
    chk_val("chg", 4'h1, ctl.charger_en);
    lvl(2250, 500, 400);
    cyc(12);
    chk_val("sw", 4'h1, ctl.switch_close);
    lvl(2100, 500, 200);
    cyc(12);
    chk_val("sw", 4'h0, ctl.switch_close);
    chk_val("chg", 4'h0, ctl.charger_en);
  endtask
  task automatic t_ov();
    go_run();
    chk_val("peak", 4'h2, ctl.peak_level);
    lvl(3300, 500, 400);
    cyc(12);
    chk_val("chg", 4'h0, ctl.charger_en);
    chk_val("pd", 4'h0, ctl.input_pulldown);
    lvl(3300, 500, 3500);
    cyc(12);
    chk_val("pd", 4'h1, ctl.input_pulldown);
    lvl(2400, 500, 400);
    cyc(12);
    chk_val("chg", 4'h1, ctl.charger_en);
  endtask
  task automatic t_therm();
    go_run();
    heat(1'b0, 70);
    cyc(12);
    chk_val("tsd", 4'h1, ctl.thermal_shutdown);
    heat(1'b0, 62);
    cyc(12);
    chk_val("tsd", 4'h1, ctl.thermal_shutdown);
    lvl(2100, 500, 400);
    cyc(12);
    chk_val("sw", 4'h0, ctl.switch_close);
    lvl(2400, 500, 400);
    heat(1'b1, 100);
    cyc(12);
    chk_val("tsd", 4'h0, ctl.thermal_shutdown);
    heat(1'b1, 125);
    cyc(12);
    chk_val("chg", 4'h0, ctl.charger_en);
    heat(1'b0, 25);
    cyc(12);
    chk_val("chg", 4'h1, ctl.charger_en);
  endtask
  task automatic t_hot();
    int n;
    rst(0, 0, 0);
    lvl(50, 3000, 0); // charged element onto an empty rail
    wait_mode(HCS_HOT_PLUG);
    chk_val("sw", 4'h1, ctl.switch_close);
    n = 0;
    while (mode === HCS_HOT_PLUG && n < 200) begin
      tick();
      n++;
    end
    chk_near("hp", HP_C, n);
    chk_val("sw", 4'h0, ctl.switch_close);
    lvl(2400, 3000, 0); // rail held up past the hot-plug window
    wait_mode(HCS_RUN);
    cyc(12);
    chk_val("sw", 4'h1, ctl.switch_close);
  endtask
  task automatic t_block();
    rst(500, 3000, 0);
    cyc(60);
    chk_val("sw", 4'h0, ctl.switch_close);
    chk_val("mode", HCS_IDLE, mode);
    lvl(2400, 3000, 0);
    wait_mode(HCS_RUN);
    cyc(12);
    chk_val("sw", 4'h0, ctl.switch_close);
    lvl(2400, 3000, 400);
    cyc(12);
    chk_val("sw", 4'h1, ctl.switch_close);
  endtask
  task automatic t_ref();
    int n;
    go_run();
    bias_gap(n);
    bias_gap(n);
    chk_near("bias", BP_C, n);
    n = 0;
    while (ctl.reference_sample !== 1'b1 && n < RF_C + 500) begin
      tick();
      n++;
    end
    chk_val("ref", 4'h1, ctl.reference_sample);
    n = 0;
    while (ctl.charger_en !== 1'b1 && n < 1000) begin
      tick();
      n++;
    end
    chk_near("refoff", RFO_C, n);
  endtask
  initial begin
    t_cold();
    t_ov();
    t_therm();
    t_hot();
    t_block();
    t_ref();
    close_out();
  end
  // scenarios above need about 7500 cycles
  initial begin
    repeat (40000) @(posedge CLK);
    n_fail++;
    close_out();
  end
endmodule
`default_nettype wire
